// *** inc/host_port_pkg.sv ***
// host pin port package: register map, field layout, timing and pin carrier types
package host_port_pkg;
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_BASE      = 8'h04;
	localparam logic [7:0]  REG_CARD      = 8'h08;
	localparam logic [7:0]  REG_RD_DATA   = 8'h0c;
	localparam logic [7:0]  REG_WR_DATA   = 8'h10;
	localparam logic [7:0]  REG_PINS      = 8'h14;
	localparam logic [7:0]  REG_IRQ_STAT  = 8'h18;
	localparam logic [7:0]  REG_IRQ_MASK  = 8'h1c;

	localparam int          CTRL_MODE_LSB = 0;
	localparam int          CTRL_WIDE_BIT = 2;
	localparam int          CTRL_SEL_LSB  = 4;
	localparam int          BASE_LSB      = 4;
	localparam int          CARD_CSR_LSB  = 8;
	localparam int          PINS_HBE_BIT  = 16;
	localparam int          PINS_RST_BIT  = 17;
	localparam int          PINS_IRQ_BIT  = 18;
	localparam int          WR_ADDR_LSB   = 16;

	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [11:0] BASE_RESET    = 12'h030;
	localparam logic [7:0]  COR_RESET     = 8'h00;
	localparam logic [7:0]  CSR_RESET     = 8'h00;
	localparam logic [3:0]  CARD_COR_ADDR = 4'h0;
	localparam logic [3:0]  CARD_CSR_ADDR = 4'h2;

	localparam int          EV_READ       = 0;
	localparam int          EV_WRITE      = 1;
	localparam int          EV_CARD       = 2;
	localparam int          EV_RESET      = 3;
	localparam int          EV_COUNT      = 4;

	localparam int          CLK_PERIOD_NS = 25;
	localparam int          RESET_MIN_NS  = 100;
	localparam int          RESET_CYCLES  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {MODE_LOCAL, MODE_CARD, MODE_STROBE, MODE_SPARE} busMode_t;
	typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE, ACC_CARD} accState_t;

	typedef struct packed {
		logic [15:0] data;
		logic [15:0] addr;
		logic        aleWe;
		logic        hbeN;
		logic        addr_qualifier;
		logic        rdN;
		logic        wrN;
		logic        hostReset;
	} hostPinIn_t;

	localparam int PIN_BITS = $bits(hostPinIn_t);
	localparam logic [PIN_BITS-1:0] PIN_IDLE = {16'h0000, 16'h0000, 6'h3e};
endpackage : host_port_pkg

// *** rtl/pin_sync.sv ***
// three-stage pin synchroniser, a change is taken once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int                WIDTH = 8,
	parameter logic [WIDTH-1:0]  INIT  = '0
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async,
	output logic      [WIDTH-1:0] stable
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
		end else begin
			stage1 <= async;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					stable[i] <= INIT[i];
				end else if (stage2[i] == stage3[i]) begin
					stable[i] <= stage3[i];
				end
			end
		end
	endgenerate
endmodule : pin_sync
`default_nettype wire

// *** rtl/reset_filter.sv ***
// minimum-width filter for the host reset level
`timescale 1ns/100ps
`default_nettype none
module reset_filter #(
	parameter int MIN_CYCLES = 4
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic rawHigh,
	output logic      level
);
	logic [7:0] highCount;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			highCount <= 8'h00;
			level     <= 1'b0;
		end else if (!rawHigh) begin
			highCount <= 8'h00;
			level     <= 1'b0;
		end else if (highCount == 8'(MIN_CYCLES - 1)) begin
			level     <= 1'b1;
		end else begin
			highCount <= highCount + 8'h01;
		end
	end

	chk_reset_min_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(level) |-> $past(rawHigh, 1) && $past(rawHigh, 2) && $past(rawHigh, 3)
			&& $past(rawHigh, 4))
		else $error("reset asserted before input stayed high long enough");
	chk_reset_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!rawHigh |=> !level)
		else $error("reset held after input fell");
endmodule : reset_filter
`default_nettype wire

// *** rtl/host_bus_pin_interface.sv ***
// host bus pin interface: strobes, address latch, interrupt routing, wide cycle pins
//
// Contract
// - host reset is active high and counts only after staying high 100 ns
// - local bus: address latch strobe falling edge holds address and high byte enable
// - local bus: interrupt high on the one selected line, other three released
// - card mode: interrupt request on line zero, active low
// - local bus: wide cycle low in 16-bit mode, qualifier low, A4-A15 match base
// - card mode: wide port low in 16-bit mode, config bit set, attribute select low
// - card mode: read acknowledge asserted during answered IO reads
// - card mode: write enable writes config option, status reg and attribute space
// - local bus: address decode only while qualifier is low
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module host_bus_pin_interface
	import host_port_pkg::*;
#(
	parameter int RESET_MIN = RESET_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             irq,
	input  wire logic [15:0] hostDataBusIn,
	output logic      [15:0] hostDataBusOut,
	output logic             hostDataBusOeN,
	input  wire logic [15:0] hostAddr,
	input  wire logic        addressLatchStrobe,
	input  wire logic        highByteEnableN,
	input  wire logic        addrQualifier,
	input  wire logic        ioReadStrobeN,
	input  wire logic        ioWriteStrobeN,
	input  wire logic        hostReset,
	input  wire logic        coreIrq,
	output logic      [3:0]  irqLine,
	output logic      [3:0]  irqLineOeN,
	output logic             wideCycleSelectN,
	output logic             wideCycleOeN,
	output logic             coreReset
);
	hostPinIn_t           pinRaw;
	hostPinIn_t           pin;
	logic                 hostRst;
	logic [7:0]           ctrl;
	logic [11:0]          baseWindow;
	logic [7:0]           cardConfigOptionReg;
	logic [7:0]           cardStatusReg;
	logic [15:0]          readData;
	logic [15:0]          wrData;
	logic [15:0]          wrAddr;
	logic [EV_COUNT-1:0]  status;
	logic [EV_COUNT-1:0]  mask;
	logic [EV_COUNT-1:0]  events;
	logic [15:0]          addrHold;
	logic                 hbeHold;
	logic [15:0]          dataHold;
	logic                 rstPrev;
	accState_t            state;
	busMode_t             mode;
	logic                 wideMode;
	logic [1:0]           irqSel;
	logic                 baseHit;
	logic                 rdReq;
	logic                 wrReq;
	logic                 cardWrReq;
	logic                 wideAssert;
	logic                 busWrPend;
	logic [7:0]           busWrAddr;
	logic                 busRead;

	assign pinRaw = '{data: hostDataBusIn, addr: hostAddr, aleWe: addressLatchStrobe,
		hbeN: highByteEnableN, addr_qualifier: addrQualifier, rdN: ioReadStrobeN,
		wrN: ioWriteStrobeN, hostReset: hostReset};

	pin_sync #(.WIDTH(PIN_BITS), .INIT(PIN_IDLE)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.async   (pinRaw),
		.stable  (pin)
	);

	reset_filter #(.MIN_CYCLES(RESET_MIN)) u_rst (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.rawHigh (pin.hostReset),
		.level   (hostRst)
	);

	function automatic logic [31:0] regRead(input logic [7:0] addr);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (addr == REG_CTRL) begin
			v[7:0] = ctrl;
		end else if (addr == REG_BASE) begin
			v[BASE_LSB +: 12] = baseWindow;
		end else if (addr == REG_CARD) begin
			v[7:0] = cardConfigOptionReg;
			v[CARD_CSR_LSB +: 8] = cardStatusReg;
		end else if (addr == REG_RD_DATA) begin
			v[15:0] = readData;
		end else if (addr == REG_WR_DATA) begin
			v = {wrAddr, wrData};
		end else if (addr == REG_PINS) begin
			v[15:0] = addrHold;
			v[PINS_HBE_BIT] = hbeHold;
			v[PINS_RST_BIT] = hostRst;
			v[PINS_IRQ_BIT] = coreIrq;
		end else if (addr == REG_IRQ_STAT) begin
			v[EV_COUNT-1:0] = status;
		end else if (addr == REG_IRQ_MASK) begin
			v[EV_COUNT-1:0] = mask;
		end
		return v;
	endfunction : regRead

	// zero wait state slave, every transfer answers OKAY
	assign busRead = hready && hsel && htrans[1] && !hwrite;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			busWrPend <= 1'b0;
			busWrAddr <= 8'h00;
			hrdata    <= 32'h0000_0000;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				busWrPend <= hsel && htrans[1] && hwrite;
				busWrAddr <= haddr[7:0];
			end
			if (busRead) begin
				hrdata <= regRead(haddr[7:0]);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl       <= CTRL_RESET;
			baseWindow <= BASE_RESET;
			readData   <= 16'h0000;
			mask       <= '0;
		end else if (busWrPend) begin
			if (busWrAddr == REG_CTRL) begin
				ctrl <= hwdata[7:0];
			end else if (busWrAddr == REG_BASE) begin
				baseWindow <= hwdata[BASE_LSB +: 12];
			end else if (busWrAddr == REG_RD_DATA) begin
				readData <= hwdata[15:0];
			end else if (busWrAddr == REG_IRQ_MASK) begin
				mask <= hwdata[EV_COUNT-1:0];
			end
		end
	end

	assign mode     = busMode_t'(ctrl[CTRL_MODE_LSB +: 2]);
	assign wideMode = ctrl[CTRL_WIDE_BIT];
	assign irqSel   = ctrl[CTRL_SEL_LSB +: 2];

	// latch stays transparent while the strobe is high, so an unused pin pulled high tracks
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addrHold <= 16'h0000;
			hbeHold  <= 1'b1;
		end else if (mode != MODE_CARD && pin.aleWe) begin
			addrHold <= pin.addr;
			hbeHold  <= pin.hbeN;
		end
	end

	always_comb begin
		baseHit    = addrHold[15:4] == baseWindow;
		rdReq      = 1'b0;
		wrReq      = 1'b0;
		cardWrReq  = 1'b0;
		wideAssert = 1'b0;
		case (mode)
			MODE_CARD: begin
				rdReq      = !pin.addr_qualifier && cardConfigOptionReg[0] && !pin.rdN;
				wrReq      = !pin.addr_qualifier && cardConfigOptionReg[0] && !pin.wrN;
				cardWrReq  = !pin.addr_qualifier && !pin.aleWe;
				wideAssert = wideMode && cardConfigOptionReg[0] && !pin.addr_qualifier;
			end
			MODE_STROBE: begin
				rdReq = baseHit && !pin.rdN && pin.wrN;
				wrReq = baseHit && !pin.rdN && !pin.wrN;
			end
			default: begin
				rdReq      = !pin.addr_qualifier && baseHit && !pin.rdN;
				wrReq      = !pin.addr_qualifier && baseHit && !pin.wrN;
				wideAssert = wideMode && !pin.addr_qualifier && baseHit;
			end
		endcase
	end

	// one operation per access: the access commits only when its strobe ends
	always_ff @(posedge clk_sys) begin
		if (!rst_n || hostRst) begin
			state    <= ACC_IDLE;
			dataHold <= 16'h0000;
		end else begin
			case (state)
				ACC_IDLE: begin
					if (rdReq) begin
						state <= ACC_READ;
					end else if (wrReq) begin
						state <= ACC_WRITE;
					end else if (cardWrReq) begin
						state <= ACC_CARD;
					end
				end
				ACC_READ: begin
					if (!rdReq) begin
						state <= ACC_IDLE;
					end
				end
				ACC_WRITE: begin
					dataHold <= pin.data;
					if (!wrReq) begin
						state <= ACC_IDLE;
					end
				end
				ACC_CARD: begin
					dataHold <= pin.data;
					if (!cardWrReq) begin
						state <= ACC_IDLE;
					end
				end
				default: state <= ACC_IDLE;
			endcase
		end
	end

	always_comb begin
		events[EV_READ]  = state == ACC_READ && !rdReq && !hostRst;
		events[EV_WRITE] = state == ACC_WRITE && !wrReq && !hostRst;
		events[EV_CARD]  = state == ACC_CARD && !cardWrReq && !hostRst;
		events[EV_RESET] = hostRst && !rstPrev;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wrData <= 16'h0000;
			wrAddr <= 16'h0000;
		end else if (events[EV_WRITE] || events[EV_CARD]) begin
			wrData <= dataHold;
			wrAddr <= events[EV_CARD] ? pin.addr : addrHold;
		end
	end

	// a pin reset puts the card configuration back to its power-on state
	always_ff @(posedge clk_sys) begin
		if (!rst_n || hostRst) begin
			cardConfigOptionReg <= COR_RESET;
			cardStatusReg       <= CSR_RESET;
		end else if (events[EV_CARD] && pin.addr[3:0] == CARD_COR_ADDR) begin
			cardConfigOptionReg <= dataHold[7:0];
		end else if (events[EV_CARD] && pin.addr[3:0] == CARD_CSR_ADDR) begin
			cardStatusReg <= dataHold[7:0];
		end else if (busWrPend && busWrAddr == REG_CARD) begin
			cardConfigOptionReg <= hwdata[7:0];
			cardStatusReg       <= hwdata[CARD_CSR_LSB +: 8];
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			status  <= '0;
			rstPrev <= 1'b0;
			irq     <= 1'b0;
		end else begin
			rstPrev <= hostRst;
			if (busWrPend && busWrAddr == REG_IRQ_STAT) begin
				status <= (status & ~hwdata[EV_COUNT-1:0]) | events;
			end else begin
				status <= status | events;
			end
			irq <= |(status & mask);
		end
	end

	// data lanes pass straight through; a strobe host crosses them on the board
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hostDataBusOut <= 16'h0000;
			hostDataBusOeN <= 1'b1;
			coreReset      <= 1'b0;
		end else begin
			hostDataBusOut <= readData;
			hostDataBusOeN <= !(rdReq && !hostRst);
			coreReset      <= hostRst;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irqLine          <= 4'h0;
			irqLineOeN       <= 4'hf;
			wideCycleSelectN <= 1'b0;
			wideCycleOeN     <= 1'b1;
		end else begin
			wideCycleSelectN <= 1'b0;
			wideCycleOeN     <= !wideAssert;
			if (mode == MODE_CARD) begin
				irqLine    <= {2'b00, 1'b0, !coreIrq};
				irqLineOeN <= {2'b11, !(rdReq && !hostRst), 1'b0};
			end else begin
				irqLine    <= {4{coreIrq}};
				irqLineOeN <= ~(4'h1 << irqSel);
			end
		end
	end

	chk_addr_latch_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode == MODE_LOCAL && !pin.aleWe ##1 mode == MODE_LOCAL |-> $stable(addrHold)
			&& $stable(hbeHold))
		else $error("address latch moved while strobe low");
	chk_addr_latch_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode == MODE_LOCAL && pin.aleWe |=> addrHold == $past(pin.addr))
		else $error("address latch did not follow while strobe high");
	chk_irq_one_line: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rst_n && mode == MODE_LOCAL |=> $countones(~irqLineOeN) == 1
			&& !irqLineOeN[$past(irqSel)] && irqLine[$past(irqSel)] == $past(coreIrq))
		else $error("local interrupt not on exactly the selected line");
	chk_card_irq_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode == MODE_CARD |=> !irqLineOeN[0] && irqLine[0] == !$past(coreIrq))
		else $error("card interrupt request not active low on line zero");
	chk_wide_local: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode == MODE_LOCAL |=> wideCycleOeN == !$past(wideMode && !pin.addr_qualifier
			&& addrHold[15:4] == baseWindow))
		else $error("wide cycle pin wrong in local mode");
	chk_wide_card: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode == MODE_CARD |=> wideCycleOeN == !$past(wideMode
			&& cardConfigOptionReg[0] && !pin.addr_qualifier))
		else $error("wide port pin wrong in card mode");
	chk_card_read_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode == MODE_CARD && rdReq && !hostRst |=> !irqLineOeN[1] && !irqLine[1]
			&& !hostDataBusOeN)
		else $error("card read not acknowledged");
	chk_cor_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		events[EV_CARD] && pin.addr[3:0] == CARD_COR_ADDR
			|=> cardConfigOptionReg == $past(dataHold[7:0]))
		else $error("card write missed the config option register");
	chk_local_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode == MODE_LOCAL && pin.addr_qualifier |=> hostDataBusOeN)
		else $error("data bus driven with qualifier high");
	chk_one_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		events[EV_WRITE] |=> !events[EV_WRITE] && state == ACC_IDLE)
		else $error("one host write gave more than one operation");
endmodule : host_bus_pin_interface
`default_nettype wire

// *** test/host_bus_model.sv ***
// host processor model driving the host pins of the port
`timescale 1ns/100ps
`default_nettype none
module host_bus_model
	import host_port_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic [15:0] hostDataBusOut,
	input  wire logic        hostDataBusOeN,
	input  wire logic        ackN,
	output logic      [15:0] hostDataBusIn,
	output logic      [15:0] hostAddr,
	output logic             addressLatchStrobe,
	output logic             highByteEnableN,
	output logic             addrQualifier,
	output logic             ioReadStrobeN,
	output logic             ioWriteStrobeN,
	output logic             hostReset
);
	logic        drv = 1'b0;
	logic [15:0] drvData = 16'h0000;
	// a released bus floats up to the weak pullups
	assign hostDataBusIn = !hostDataBusOeN ? hostDataBusOut : (drv ? drvData : 16'hffff);
	initial begin
		hostAddr = 16'h0000;
		addressLatchStrobe = 1'b1;
		highByteEnableN = 1'b1;
		addrQualifier = 1'b1;
		ioReadStrobeN = 1'b1;
		ioWriteStrobeN = 1'b1;
		hostReset = 1'b0;
	end

	task automatic present(input logic [15:0] a, input logic aenV);
		@(posedge clk_sys);
		hostAddr        <= a;
		addrQualifier   <= aenV;
		highByteEnableN <= 1'b0;
	endtask : present

	task automatic access(input busMode_t m, input logic rd, input logic [15:0] a,
		input logic aenV, input logic [15:0] w, output logic [15:0] r, output logic ans,
		output logic ack);
		int i;
		present(a, aenV);
		repeat (6) @(posedge clk_sys);
		if (m == MODE_LOCAL) begin
			addressLatchStrobe <= 1'b0;
			@(posedge clk_sys);
			hostAddr <= ~a; // address hold time over, lines change
		end
		@(posedge clk_sys);
		drv     <= !rd;
		drvData <= (m == MODE_STROBE) ? {w[7:0], w[15:8]} : w;
		if (m == MODE_STROBE)
			ioWriteStrobeN <= rd;
		@(posedge clk_sys);
		if (m == MODE_CARD && !rd)
			addressLatchStrobe <= 1'b0;
		else if (rd || m == MODE_STROBE)
			ioReadStrobeN <= 1'b0;
		else
			ioWriteStrobeN <= 1'b0;
		ans = 1'b0;
		for (i = 0; i < 12 && rd && !ans; i++) begin
			@(posedge clk_sys);
			ans = !hostDataBusOeN;
		end
		repeat (rd ? 2 : 8) @(posedge clk_sys);
		r   = (m == MODE_STROBE) ? {hostDataBusIn[7:0], hostDataBusIn[15:8]} : hostDataBusIn;
		ack = !ackN;
		ioReadStrobeN      <= 1'b1;
		ioWriteStrobeN     <= 1'b1;
		addressLatchStrobe <= 1'b1;
		@(posedge clk_sys);
		drv           <= 1'b0;
		addrQualifier <= 1'b1;
		// strobes stay high long enough to be seen apart
		repeat (6) @(posedge clk_sys);
	endtask : access

	task automatic pulse(input int n);
		@(posedge clk_sys);
		hostReset <= 1'b1;
		repeat (n) @(posedge clk_sys);
		hostReset <= 1'b0;
	endtask : pulse
endmodule : host_bus_model
`default_nettype wire

// *** test/test_host_bus_pin_interface.sv ***
// testbench for the host bus pin interface
`timescale 1ns/100ps
`default_nettype none
module test_host_bus_pin_interface;
	import host_port_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        coreIrq = 1'b0;
	logic        sawReset = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, irq, hostDataBusOeN, wideCycleSelectN, wideCycleOeN;
	logic        coreReset, addressLatchStrobe, highByteEnableN, addrQualifier;
	logic        ioReadStrobeN, ioWriteStrobeN, hostReset;
	logic [15:0] hostDataBusIn, hostDataBusOut, hostAddr;
	logic [3:0]  irqLine, irqLineOeN;
	int          nMismatch = 0;
	int          checks = 0;
	logic [31:0] wideCtrl [4] = '{32'h4, 32'h4, 32'h4, 32'h0};
	logic [15:0] wideAddr [4] = '{16'h0305, 16'h0315, 16'h0305, 16'h0305};
	logic        wideAen  [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
	logic        wideExp  [4] = '{1'b0, 1'b1, 1'b1, 1'b1};

	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (coreReset === 1'b1) sawReset <= 1'b1;

	host_bus_pin_interface #(.RESET_MIN(RESET_CYCLES)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .irq(irq), .hostDataBusIn(hostDataBusIn),
		.hostDataBusOut(hostDataBusOut), .hostDataBusOeN(hostDataBusOeN), .hostAddr(hostAddr),
		.addressLatchStrobe(addressLatchStrobe), .highByteEnableN(highByteEnableN),
		.addrQualifier(addrQualifier), .ioReadStrobeN(ioReadStrobeN),
		.ioWriteStrobeN(ioWriteStrobeN), .hostReset(hostReset), .coreIrq(coreIrq),
		.irqLine(irqLine), .irqLineOeN(irqLineOeN), .wideCycleSelectN(wideCycleSelectN),
		.wideCycleOeN(wideCycleOeN), .coreReset(coreReset));

	host_bus_model host (.clk_sys(clk_sys), .hostDataBusOut(hostDataBusOut),
		.hostDataBusOeN(hostDataBusOeN), .ackN(irqLine[1] | irqLineOeN[1]),
		.hostDataBusIn(hostDataBusIn), .hostAddr(hostAddr),
		.addressLatchStrobe(addressLatchStrobe), .highByteEnableN(highByteEnableN),
		.addrQualifier(addrQualifier), .ioReadStrobeN(ioReadStrobeN),
		.ioWriteStrobeN(ioWriteStrobeN), .hostReset(hostReset));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, nMismatch);
		if (nMismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task automatic checkReg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			nMismatch++;
			$display("unexpected at %0t: register %h expected %h", $time, got, exp);
		end
	endtask : checkReg

	task automatic checkPin(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			nMismatch++;
			$display("unexpected at %0t: pins %h expected %h", $time, got, exp);
		end
	endtask : checkPin

	// samples before the edge, as registered outputs only move on it
	task automatic waitReady(output logic [31:0] r);
		// no limit here: a hung slave is caught by the watchdog
		@(negedge clk_sys);
		while (hreadyout !== 1'b1) begin
			@(negedge clk_sys);
		end
		r = hrdata;
		@(posedge clk_sys);
	endtask : waitReady

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] w,
		output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		waitReady(r);
		htrans <= 2'b00;
		hwdata <= w;
		waitReady(r);
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		logic [31:0] r;
		ahb(1'b1, a, w, r);
	endtask : wr

	task automatic regCheck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		checkReg(r & m, e);
	endtask : regCheck

	initial begin
		repeat (40000) @(posedge clk_sys);
		nMismatch++;
		end_sim();
	end

	initial begin
		logic [15:0] r;
		logic        ans, ack;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		checkPin({9'h0, irqLineOeN, wideCycleOeN, hostDataBusOeN, coreReset}, 16'h007e);
		checkPin({14'h0, hresp, wideCycleSelectN}, 16'h0000);
		regCheck(REG_CTRL, 32'hff, 32'h0);
		regCheck(REG_BASE, 32'hfff0, 32'h300);
		regCheck(8'h40, 32'hffffffff, 32'h0);
		coreIrq <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			wr(REG_CTRL, 32'(s) << CTRL_SEL_LSB);
			repeat (6) @(posedge clk_sys);
			checkPin({11'h0, irqLineOeN, irqLine[s]}, {11'h0, ~(4'h1 << s), 1'b1});
		end
		wr(REG_CTRL, 32'h1);
		repeat (6) @(posedge clk_sys);
		checkPin({14'h0, irqLineOeN[0], irqLine[0]}, 16'h0000);
		wr(REG_CTRL, 32'h2);
		repeat (6) @(posedge clk_sys);
		checkPin({14'h0, irqLineOeN[0], irqLine[0]}, 16'h0001);
		wr(REG_CTRL, 32'h3);
		repeat (6) @(posedge clk_sys);
		checkPin({11'h0, irqLineOeN, irqLine[0]}, 16'h001d);
		coreIrq <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			wr(REG_CTRL, wideCtrl[k]);
			host.present(wideAddr[k], wideAen[k]);
			repeat (10) @(posedge clk_sys);
			checkPin({15'h0, wideCycleOeN}, {15'h0, wideExp[k]});
		end
		wr(REG_CTRL, 32'h4);
		wr(REG_RD_DATA, 32'h5a3c);
		wr(REG_IRQ_STAT, 32'hf);
		host.access(MODE_LOCAL, 1'b1, 16'h0305, 1'b0, 16'h0, r, ans, ack);
		checkPin(r, 16'h5a3c);
		host.access(MODE_LOCAL, 1'b1, 16'h0305, 1'b1, 16'h0, r, ans, ack);
		checkPin({r[14:0], ans}, 16'hfffe);
		host.access(MODE_LOCAL, 1'b1, 16'h0405, 1'b0, 16'h0, r, ans, ack);
		checkPin({15'h0, ans}, 16'h0000);
		host.access(MODE_LOCAL, 1'b0, 16'h0302, 1'b0, 16'hbeef, r, ans, ack);
		regCheck(REG_WR_DATA, 32'hffffffff, 32'h0302beef);
		regCheck(REG_IRQ_STAT, 32'hf, 32'h3);
		checkPin({15'h0, irq}, 16'h0000);
		wr(REG_IRQ_MASK, 32'h2);
		// the level follows the mask one cycle late
		repeat (2) @(posedge clk_sys);
		checkPin({15'h0, irq}, 16'h0001);
		wr(REG_IRQ_STAT, 32'h2);
		regCheck(REG_IRQ_STAT, 32'hf, 32'h1);
		checkPin({15'h0, irq}, 16'h0000);
		wr(REG_CTRL, 32'h5);
		host.access(MODE_CARD, 1'b0, 16'h0000, 1'b0, 16'h0001, r, ans, ack);
		host.access(MODE_CARD, 1'b0, 16'h0002, 1'b0, 16'h00a5, r, ans, ack);
		regCheck(REG_CARD, 32'hffff, 32'ha501);
		regCheck(REG_IRQ_STAT, 32'h4, 32'h4);
		host.present(16'h0000, 1'b0);
		repeat (10) @(posedge clk_sys);
		checkPin({15'h0, wideCycleOeN}, 16'h0000);
		host.present(16'h0000, 1'b1);
		repeat (10) @(posedge clk_sys);
		checkPin({15'h0, wideCycleOeN}, 16'h0001);
		wr(REG_RD_DATA, 32'h1357);
		host.access(MODE_CARD, 1'b1, 16'h0000, 1'b0, 16'h0, r, ans, ack);
		checkPin(r, 16'h1357);
		checkPin({15'h0, ack}, 16'h0001);
		wr(REG_CTRL, 32'h6);
		wr(REG_RD_DATA, 32'h1234);
		host.access(MODE_STROBE, 1'b1, 16'h0300, 1'b0, 16'h0, r, ans, ack);
		checkPin(r, 16'h3412);
		host.access(MODE_STROBE, 1'b0, 16'h0300, 1'b0, 16'habcd, r, ans, ack);
		regCheck(REG_WR_DATA, 32'hffff, 32'hcdab);
		host.pulse(3);
		repeat (16) @(posedge clk_sys);
		checkPin({15'h0, sawReset}, 16'h0000);
		host.pulse(6);
		repeat (12) @(posedge clk_sys);
		checkPin({15'h0, sawReset}, 16'h0001);
		regCheck(REG_IRQ_STAT, 32'h8, 32'h8);
		regCheck(REG_CARD, 32'hffff, 32'h0);
		end_sim();
	end
endmodule : test_host_bus_pin_interface
`default_nettype wire
